// File: mrs_pkg.sv
// What this block does
// - restore fills registers of one file only
// - restore adds 32 to pointer after each
// - restore handles highest numbered register first
// - save subtracts 32 before each write
// - save stores lowest numbered register first
// - save leaves pointer at highest register
// - stack grows down, pointer ends at top
// - pointer in same file; stack pointer shared
// - bit 4 picks file, low bits pointer
// - restore mask bit n selects register n
// - save mask reversed, bit 15 is register 0
// - status flags never touched by either
// - unselected registers other than the pointer keep their values
// - stack pointer as pointer adjusts system stack
package mrs_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CMD    = 12'h000;
	localparam logic [11:0] OFS_MASK   = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_FLAGS  = 12'h00c;
	localparam logic [11:0] OFS_RF     = 12'h100;
	localparam int          RF_SEL_BIT = 8;
	localparam int          RF_FILE_BIT = 6;
	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int          CMD_GO_BIT   = 31;
	localparam int          CMD_FILE_BIT = 4;
	localparam int          CMD_SAVE_BIT = 5;
	localparam int          ST_BUSY_BIT  = 0;
	localparam int          ST_DONE_BIT  = 1;
	localparam logic [15:0] CMD_RESET    = 16'h0000;
	localparam logic [15:0] MASK_RESET   = 16'h0000;
	localparam logic [3:0]  FLAGS_RESET  = 4'h0;
	localparam logic [3:0]  SP_INDEX     = 4'hf;
	// ----------------------------------------------------------------
	// stack geometry, bit addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] LONG_STEP = 32'h0000_0020;
	localparam logic [31:0] HALF_STEP = 32'h0000_0010;
endpackage

// File: mrs_mem_if.sv
`timescale 1ns/100ps
interface mrs_mem_if;
	logic        start;
	logic        we;
	logic [31:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport eng  (output start, we, addr, wdata, input done, rdata);
	modport port (input start, we, addr, wdata, output done, rdata);
endinterface

// File: mrs_regfile.sv
`timescale 1ns/100ps
module mrs_regfile #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 32
) (
	input  wire logic                     pclk,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [WIDTH-1:0]         rdata
);
	// no reset: contents are software state, read data is registered
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2)
	begin : g_depth_check
		$error("mrs_regfile: DEPTH too small");
	end

	always_ff @(posedge pclk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule

// File: mrs_memport.sv
`timescale 1ns/100ps
module mrs_memport (
	input  wire logic        pclk,
	input  wire logic        presetn,
	mrs_mem_if.port          eng,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack
);
	// one half-word access at a time; request holds until acknowledged
	wire take_ack = mem_req & mem_ack;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= 32'h0000_0000;
			mem_wdata <= 16'h0000;
			eng.done  <= 1'b0;
			eng.rdata <= 16'h0000;
		end
		else
		begin
			eng.done <= take_ack;
			if (take_ack)
			begin
				mem_req   <= 1'b0;
				eng.rdata <= mem_rdata;
			end
			else if (eng.start && !mem_req)
			begin
				mem_req   <= 1'b1;
				mem_we    <= eng.we;
				mem_addr  <= eng.addr;
				mem_wdata <= eng.wdata;
			end
		end
	end
endmodule

// File: mrs_top.sv
`timescale 1ns/100ps
module mrs_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             busy
);
	// ----------------------------------------------------------------
	// types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		S_IDLE  = 9'h001,
		S_PTRRD = 9'h002,
		S_PTRCP = 9'h004,
		S_PICK  = 9'h008,
		S_REGRD = 9'h010,
		S_LO    = 9'h020,
		S_HI    = 9'h040,
		S_WRREG = 9'h080,
		S_WRPTR = 9'h100
	} mrs_state_e;

	// the stack pointer is one shared entry, seen from either file
	function automatic logic [4:0] phys(input logic f, input logic [3:0] r);
		phys = {f & (r != mrs_pkg::SP_INDEX), r};
	endfunction

	function automatic logic [3:0] highest(input logic [15:0] v);
		highest = 4'h0;
		for (int i = 0; i < 16; i++)
			if (v[i])
				highest = 4'(i);
	endfunction

	function automatic logic [3:0] lowest(input logic [15:0] v);
		lowest = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (v[i])
				lowest = 4'(i);
	endfunction

	function automatic logic [15:0] reverse(input logic [15:0] v);
		for (int i = 0; i < 16; i++)
			reverse[i] = v[15-i];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mrs_state_e  state_reg;
	logic [15:0] cmd_reg;
	logic [15:0] mask_reg;
	logic [3:0]  flags_reg;
	logic        done_reg;
	logic [4:0]  count_reg;
	logic        save_reg;
	logic        file_reg;
	logic [3:0]  rp_reg;
	logic [15:0] sel_reg;
	logic [3:0]  cur_reg;
	logic [31:0] ptr_reg;
	logic [15:0] lo_reg;
	logic        issued_reg;
	logic        rd_ok_reg;
	logic [31:0] rf_rdata;

	mrs_mem_if mi ();

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire        idle      = state_reg == S_IDLE;
	wire        acc       = psel & penable & ~pready;
	wire        hit_cmd   = paddr == mrs_pkg::OFS_CMD;
	wire        hit_mask  = paddr == mrs_pkg::OFS_MASK;
	wire        hit_stat  = paddr == mrs_pkg::OFS_STATUS;
	wire        hit_flags = paddr == mrs_pkg::OFS_FLAGS;
	localparam int RF_TOP = mrs_pkg::RF_SEL_BIT;
	localparam logic [11-RF_TOP:0] RF_BASE =
		mrs_pkg::OFS_RF[11:RF_TOP];
	wire        hit_rf    = paddr[11:RF_TOP] == RF_BASE &&
	                        paddr[1:0] == 2'b00;
	wire        hit_any   = hit_cmd | hit_mask | hit_stat | hit_flags |
	                        hit_rf;
	// register file accesses wait for the engine to go idle
	wire        can_ans   = ~hit_rf | (idle & rd_ok_reg);
	wire        answer    = acc & can_ans;
	// writes land only at the edge where the master sees pready high
	wire        wr        = psel & penable & pready & pwrite;
	wire [3:0]  apb_reg   = paddr[5:2];
	wire        apb_file  = paddr[mrs_pkg::RF_FILE_BIT];
	wire        go        = wr & hit_cmd & pwdata[mrs_pkg::CMD_GO_BIT] &
	                        idle;
	wire        st_clr    = wr & hit_stat & pwdata[mrs_pkg::ST_DONE_BIT];

	// ----------------------------------------------------------------
	// engine decode
	// ----------------------------------------------------------------
	wire [15:0] go_sel  = pwdata[mrs_pkg::CMD_SAVE_BIT] ?
	                      reverse(mask_reg) : mask_reg;
	wire [3:0]  pick    = save_reg ? lowest(sel_reg) :
	                                 highest(sel_reg);
	wire        in_ptr  = state_reg == S_PTRRD || state_reg == S_PTRCP;
	wire [4:0]  rf_raddr = idle   ? phys(apb_file, apb_reg) :
	                       in_ptr ? phys(file_reg, rp_reg) :
	                                phys(file_reg, cur_reg);
	wire        eng_wr  = state_reg == S_WRREG || state_reg == S_WRPTR;
	wire        rf_we   = eng_wr | (wr & hit_rf & idle);
	wire [4:0]  rf_waddr = !eng_wr ? phys(apb_file, apb_reg) :
	                       state_reg == S_WRPTR ? phys(file_reg, rp_reg) :
	                                              phys(file_reg, cur_reg);
	// restore writes the register just popped, then the pointer; others stay put
	wire [31:0] rf_wdata = !eng_wr ? pwdata :
	                       state_reg == S_WRPTR ? ptr_reg :
	                                              {mi.rdata, lo_reg};
	wire        in_hi   = state_reg == S_HI;
	wire        in_mem  = state_reg == S_LO || in_hi;

	// low half at the pointer, high half one half-word above
	assign mi.start = in_mem & ~issued_reg;
	assign mi.we    = save_reg;
	assign mi.addr  = in_hi ? ptr_reg + mrs_pkg::HALF_STEP :
	                          ptr_reg;
	assign mi.wdata = in_hi ? rf_rdata[31:16] : rf_rdata[15:0];

	wire [31:0] rd_mux =
		hit_cmd   ? {16'h0000, cmd_reg} :
		hit_mask  ? {16'h0000, mask_reg} :
		hit_stat  ? {count_reg, 25'h0, done_reg, ~idle} :
		hit_flags ? {28'h0000000, flags_reg} :
		hit_rf    ? rf_rdata : 32'h0000_0000;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	mrs_regfile #(
		.DEPTH (32),
		.WIDTH (32)
	) u_rf (
		.pclk  (pclk),
		.we    (rf_we),
		.waddr (rf_waddr),
		.wdata (rf_wdata),
		.raddr (rf_raddr),
		.rdata (rf_rdata)
	);

	mrs_memport u_mp (
		.pclk      (pclk),
		.presetn   (presetn),
		.eng       (mi.port),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack)
	);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h0000_0000;
			rd_ok_reg <= 1'b0;
			cmd_reg   <= mrs_pkg::CMD_RESET;
			mask_reg  <= mrs_pkg::MASK_RESET;
			flags_reg <= mrs_pkg::FLAGS_RESET;
		end
		else
		begin
			// read port carried the bus address in the previous cycle
			rd_ok_reg <= idle;
			pready    <= answer;
			pslverr   <= answer & ~hit_any;
			if (answer && !pwrite)
				prdata <= rd_mux;
			if (wr && hit_cmd && idle)
				cmd_reg <= pwdata[15:0];
			if (wr && hit_mask && idle)
				mask_reg <= pwdata[15:0];
			// flags belong to software; the engine has no path here
			if (wr && hit_flags)
				flags_reg <= pwdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// move engine
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg  <= S_IDLE;
			busy       <= 1'b0;
			done_reg   <= 1'b0;
			count_reg  <= 5'h00;
			save_reg   <= 1'b0;
			file_reg   <= 1'b0;
			rp_reg     <= 4'h0;
			sel_reg    <= 16'h0000;
			cur_reg    <= 4'h0;
			ptr_reg    <= 32'h0000_0000;
			lo_reg     <= 16'h0000;
			issued_reg <= 1'b0;
		end
		else
		begin
			if (st_clr)
				done_reg <= 1'b0;
			if (mi.start)
				issued_reg <= 1'b1;
			else if (mi.done)
				issued_reg <= 1'b0;
			case (state_reg)
			S_IDLE:
				if (go)
				begin
					// operation is taken from the command write itself
					save_reg  <= pwdata[mrs_pkg::CMD_SAVE_BIT];
					file_reg  <= pwdata[mrs_pkg::CMD_FILE_BIT];
					rp_reg    <= pwdata[3:0];
					sel_reg   <= go_sel;
					count_reg <= 5'h00;
					// an empty list leaves memory and pointer alone
					if (mask_reg == 16'h0000)
						done_reg <= 1'b1;
					else
					begin
						state_reg <= S_PTRRD;
						busy      <= 1'b1;
					end
				end
			S_PTRRD:
				state_reg <= S_PTRCP;
			S_PTRCP:
			begin
				ptr_reg   <= rf_rdata;
				state_reg <= S_PICK;
			end
			S_PICK:
				if (sel_reg == 16'h0000)
					state_reg <= S_WRPTR;
				else
				begin
					cur_reg          <= pick;
					sel_reg[pick]    <= 1'b0;
					count_reg        <= count_reg + 5'h01;
					if (save_reg)
						ptr_reg <= ptr_reg - mrs_pkg::LONG_STEP;
					state_reg <= S_REGRD;
				end
			S_REGRD:
				state_reg <= S_LO;
			S_LO:
				if (mi.done)
				begin
					lo_reg    <= mi.rdata;
					state_reg <= S_HI;
				end
			S_HI:
				if (mi.done)
					state_reg <= save_reg ? S_PICK : S_WRREG;
			S_WRREG:
			begin
				ptr_reg   <= ptr_reg + mrs_pkg::LONG_STEP;
				state_reg <= S_PICK;
			end
			S_WRPTR:
			begin
				// pointer ends at new top of stack
				state_reg <= S_IDLE;
				busy      <= 1'b0;
				done_reg  <= 1'b1;
			end
			default:
			begin
				state_reg <= S_IDLE;
				busy      <= 1'b0;
			end
			endcase
		end
	end
endmodule

// File: mrs_top_monitor.sv
`timescale 1ns/100ps
module mrs_top_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic        mem_ack,
	input wire logic        busy
);
	// ----------------------------------------------------------------
	// engine state rebuilt from the ports, bodies being opaque
	// ----------------------------------------------------------------
	logic        hc_reg;
	logic        seen_reg;
	logic        save_reg;
	logic [31:0] last_reg;
	logic [15:0] mask_reg;
	logic [5:0]  acks_reg;
	wire         wr_ok = psel && penable && pready && pwrite && !busy;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hc_reg   <= 1'b0;
			seen_reg <= 1'b0;
			save_reg <= 1'b0;
			last_reg <= 32'h0000_0000;
			mask_reg <= 16'h0000;
			acks_reg <= 6'h00;
		end
		else
		begin
			if (wr_ok && paddr == mrs_pkg::OFS_MASK)
				mask_reg <= pwdata[15:0];
			if (wr_ok && paddr == mrs_pkg::OFS_CMD)
				save_reg <= pwdata[mrs_pkg::CMD_SAVE_BIT];
			if (!busy)
			begin
				hc_reg   <= 1'b0;
				seen_reg <= 1'b0;
				acks_reg <= 6'h00;
			end
			else if (mem_req && mem_ack)
			begin
				hc_reg   <= !hc_reg;
				seen_reg <= 1'b1;
				last_reg <= mem_addr;
				acks_reg <= acks_reg + 6'h01;
			end
		end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_go;
		wr_ok && paddr == mrs_pkg::OFS_CMD && pwdata[mrs_pkg::CMD_GO_BIT];
	endsequence
	sequence s_run_go;
		s_go ##0 mask_reg != 16'h0000;
	endsequence
	sequence s_zero_go;
		s_go ##0 mask_reg == 16'h0000;
	endsequence
	a_go_starts_op: assert property (
		s_run_go |-> ##[0:3] busy) else $error("engine did not start");
	a_zero_mask_quiet: assert property (
		s_zero_go |=> !busy [*4]) else $error("empty mask started engine");
	a_req_needs_busy: assert property (
		mem_req |-> busy) else $error("memory request while idle");
	a_req_holds_steady: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata))
		else $error("request changed before ack");
	a_dir_follows_cmd: assert property (
		mem_req |-> mem_we == save_reg) else $error("wrong direction");
	a_half_pair_addr: assert property (
		$rose(mem_req) && hc_reg |-> mem_addr == last_reg + 32'h10)
		else $error("high half misplaced");
	a_next_reg_addr: assert property (
		$rose(mem_req) && seen_reg && !hc_reg |-> mem_addr ==
		(save_reg ? last_reg - 32'h30 : last_reg + 32'h10))
		else $error("pointer step wrong");
	a_ack_count_match: assert property (
		$fell(busy) |-> acks_reg == 6'(2 * $countones(mask_reg)))
		else $error("access count wrong");
endmodule
bind mrs_top mrs_top_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.busy(busy));

// File: mrs_mem_model.sv
`timescale 1ns/100ps
module mrs_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	logic [15:0] mem [logic [31:0]];
	logic [31:0] acc_q [$];
	int          delay = 0;
	int          wait_cnt;
	logic        served;
	// one ack per request; the request must drop before the next is served
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_cnt  <= 0;
			served    <= 1'b0;
		end
		else if (mem_ack)
		begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata; // stale data must never look valid
		end
		else if (!mem_req)
		begin
			served   <= 1'b0;
			wait_cnt <= 0;
		end
		else if (!served && wait_cnt < delay)
			wait_cnt <= wait_cnt + 1;
		else if (!served)
		begin
			mem_ack <= 1'b1;
			served  <= 1'b1;
			acc_q.push_back(mem_addr);
			if (mem_we)
				mem[mem_addr] = mem_wdata;
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
		end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, mem_addr, rd;
	logic [15:0] mem_wdata, mem_rdata;
	logic        pready, pslverr, mem_req, mem_we, mem_ack, busy, err;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #2.5 pclk = ~pclk;
	mrs_top uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.busy(busy));
	mrs_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen, then one idle edge before the next
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [11:0] ra(input logic f, input int n);
		return mrs_pkg::OFS_RF + {5'h00, f, n[3:0], 2'b00};
	endfunction
	function automatic logic [31:0] val(input int n);
		return 32'h1357_0000 + 32'(n) * 32'h0001_0101;
	endfunction
	task automatic op(input logic f, input logic [3:0] p, input logic s,
		input logic [15:0] m);
		apb(1'b1, mrs_pkg::OFS_MASK, {16'h0000, m});
		apb(1'b1, mrs_pkg::OFS_CMD, {1'b1, 25'h0, s, f, p});
		rd = 32'h0;
		while (rd[mrs_pkg::ST_DONE_BIT] !== 1'b1)
			apb(1'b0, mrs_pkg::OFS_STATUS, 32'h0);
		apb(1'b1, mrs_pkg::OFS_STATUS, 32'h0000_0002);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 12'h800, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, mrs_pkg::OFS_FLAGS, 32'h0000_000a);
		$display("register test done");
	endtask
	task automatic t_save;
		logic [15:0] sel = 16'hf115;
		logic [31:0] p = 32'h0010_0000;
		logic [31:0] v;
		int          k = u_mem.acc_q.size();
		for (int n = 0; n < 16; n++)
			apb(1'b1, ra(1'b0, n), n == 1 ? p : val(n));
		op(1'b0, 4'h1, 1'b1, 16'ha88f);
		for (int n = 0; n < 16; n++)
			if (sel[n])
			begin
				v = val(n);
				p = p - 32'h20;
				chk(32'(u_mem.mem[p]), 32'(v[15:0]));
				chk(32'(u_mem.mem[p + 32'h10]), 32'(v[31:16]));
				chk(u_mem.acc_q[k], p);
				k += 2;
			end
		apb(1'b0, ra(1'b0, 1), 32'h0);
		chk(rd, p);
		$display("save test done");
	endtask
	task automatic t_restore;
		logic [15:0] sel = 16'hf08e;
		logic [31:0] p = 32'h0001_0000;
		logic [31:0] v;
		for (int n = 15; n >= 0; n--)
			if (sel[n])
			begin
				v = ~val(n);
				u_mem.mem[p] = v[15:0];
				u_mem.mem[p + 32'h10] = v[31:16];
				p = p + 32'h20;
			end
		for (int n = 0; n < 16; n++)
			apb(1'b1, ra(1'b1, n), n == 0 ? 32'h0001_0000 : val(n));
		u_mem.delay = 3;
		op(1'b1, 4'h0, 1'b0, sel);
		u_mem.delay = 0;
		for (int n = 1; n < 16; n++)
		begin
			apb(1'b0, ra(1'b1, n), 32'h0);
			chk(rd, sel[n] ? ~val(n) : val(n));
		end
		apb(1'b0, ra(1'b1, 0), 32'h0);
		chk(rd, p);
		apb(1'b0, ra(1'b0, 3), 32'h0);
		chk(rd, val(3));
		$display("restore test done");
	endtask
	task automatic t_sp_zero;
		int k = u_mem.acc_q.size();
		apb(1'b1, ra(1'b1, 15), 32'h0002_0000);
		apb(1'b1, ra(1'b1, 3), val(3));
		op(1'b1, 4'hf, 1'b1, 16'h1000);
		chk(u_mem.acc_q[k], 32'h0001_ffe0);
		apb(1'b0, ra(1'b0, 15), 32'h0);
		chk(rd, 32'h0001_ffe0);
		op(1'b0, 4'h2, 1'b1, 16'h0000);
		chk(32'(u_mem.acc_q.size()), 32'(k + 2));
		apb(1'b0, mrs_pkg::OFS_FLAGS, 32'h0);
		chk(rd, 32'h0000_000a);
		$display("stack pointer and empty mask test done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// the tests need well under a thousand cycles; a hang is cut off well after
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_save();
		t_restore();
		t_sp_zero();
		summarize();
	end
endmodule
